/* processor_trace_status_port_tb.sv */
// Purpose: self-checking bench for the trace status port
// Assumes: apb slave answers with zero wait states
// Notes: random data from a fixed lfsr seed
`timescale 1ns/1ps
module processor_trace_status_port_tb;
   import ptsp_pkg::*;
   logic clk = 1'b0, tclk = 1'b0, rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, lf = 32'h78BD, prdata, rd, cap_word;
   logic pready, pslverr, er, tco, toe, scan, doe, pdn;
   logic sel = 1'b1, flt_n = 1'b1, rin_n = 1'b1, wake_n = 1'b1;
   logic [3:0] pst, dd, cap_code;
   int failures = 0, total_checks = 0, tco_cnt = 0, k;
   always #2 clk = ~clk;
   initial #7 forever #16 tclk = ~tclk;
   always @(posedge tco) tco_cnt++;
   ptsp_top u_ptsp_top (.sys_clk_i(clk), .rst_b_i(rst_b), .trace_clk_i(tclk), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .debug_interface_select_i(sel),
      .test_mode_hi_i(2'b00),
      .output_float_n_i(flt_n), .reset_in_n_i(rin_n), .wake_up_n_i(wake_n), .trace_clock_out_o(tco),
      .processor_status_code_o(pst), .debug_data_nibble_o(dd), .trace_oe_o(toe),
      .scan_owns_pins_o(scan), .data_bus_oe_o(doe), .power_down_o(pdn));
   ptsp_trace_cap u_ptsp_trace_cap (.trace_clk_i(tclk), .rst_b_i(rst_b), .status_i(pst),
      .nibble_i(dd), .word_o(cap_word), .code_o(cap_code));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] exp_word(input logic [3:0] c, input logic [31:0] d);
      return d & (32'hFFFFFFFF >> (8 * (11 - c)));
   endfunction
   task automatic test_done();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk("pready", 1, pready);
      if (pready !== 1'b1)
         test_done();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_sts(input logic [3:0] v);
      for (k = 0; k < 300 && pst !== v; k++)
         @(posedge clk);
      chk("status", v, pst);
      if (pst !== v)
         test_done();
   endtask
   task automatic wait_idle();
      rd = 32'h1;
      for (int n = 0; n < 50 && rd[0] !== 1'b0; n++)
         apb(1'b0, PTSP_OFS_STAT, 32'h0);
      chk("busy", 0, rd[0]);
      if (rd[0] !== 1'b0)
         test_done();
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, PTSP_OFS_CTRL, 32'h0);
      chk("ctrl reset", {28'h0, PTSP_BKPT_RST}, rd);
      apb(1'b0, PTSP_OFS_DATA, 32'h0);
      chk("data reset", PTSP_DATA_RST, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 1, er);
      apb(1'b1, PTSP_OFS_STAT, 32'hFF);
      chk("stat write", 1, er);
      apb(1'b0, PTSP_OFS_STAT, 32'h0);
      chk("straps", 0, rd[4:3]);
      k = tco_cnt;
      repeat (8) @(posedge tclk);
      #1;
      chk("trace clock", 8, tco_cnt - k);
      for (int c = 0; c < 16; c++)
      begin
         lf = nxt(lf);
         apb(1'b1, PTSP_OFS_DATA, lf);
         apb(1'b1, PTSP_OFS_CMD, {20'h0, 1'b0, lf[14:12], 4'h0, 4'(c)});
         chk("cmd refuse", (c == 2 || c == 6), er);
         wait_idle();
         repeat (20) @(posedge tclk);
         if (c >= 8 && c <= 11)
         begin
            chk("nibbles", exp_word(4'(c), lf), cap_word);
            chk("xfer code", c, cap_code);
         end
      end
      apb(1'b0, PTSP_OFS_CMD, 32'h0);
      chk("cmd read", {20'h0, (({1'b0, lf[14:12]} < PTSP_HOLD_MIN) ? PTSP_HOLD_MIN : {1'b0, lf[14:12]}), 8'h0F}, rd);
      apb(1'b0, PTSP_OFS_DATA, 32'h0);
      chk("data read", lf, rd);
      apb(1'b1, PTSP_OFS_CTRL, 32'h5);
      repeat (4) @(posedge tclk);
      chk("bkpt nibble", 5, dd);
      apb(1'b1, PTSP_OFS_CTRL, 32'h15);
      wait_sts(PTSP_ST_STOPPED);
      wake_n <= 1'b0;
      for (k = 0; k < 50 && pdn !== 1'b0; k++)
         @(posedge clk);
      chk("wake", 0, pdn);
      repeat (4) @(posedge clk);
      wake_n <= 1'b1;
      wait_sts(PTSP_ST_CONTINUE);
      rin_n <= 1'b0;
      wait_sts(PTSP_ST_EXCEPT);
      apb(1'b0, PTSP_OFS_STAT, 32'h0);
      chk("reset seen", 1, rd[5]);
      chk("bus release", 0, doe);
      rin_n <= 1'b1;
      wait_sts(PTSP_ST_CONTINUE);
      flt_n <= 1'b0;
      @(posedge clk);
      #1;
      chk("float trace", 0, toe);
      chk("float bus", 0, doe);
      @(posedge clk);
      sel <= 1'b0;
      repeat (5) @(posedge clk);
      chk("scan owns", 1, scan);
      flt_n <= 1'b1;
      repeat (40) @(posedge clk);
      chk("trace scan", 0, toe);
      sel <= 1'b1;
      repeat (40) @(posedge clk);
      chk("debug owns", 0, scan);
      chk("trace drive", 1, toe);
      test_done();
   end
endmodule // processor_trace_status_port_tb

/* ptsp_pkg.sv */
// Purpose: shared constants and types for the processor trace status port
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: register map and field positions live here only
package ptsp_pkg;

   // register byte offsets
   localparam logic [7:0] PTSP_OFS_CTRL = 8'h00;
   localparam logic [7:0] PTSP_OFS_STAT = 8'h04;
   localparam logic [7:0] PTSP_OFS_DATA = 8'h08;
   localparam logic [7:0] PTSP_OFS_CMD = 8'h0C;

   // ctrl fields
   localparam int PTSP_CTRL_BKPT_LSB = 0;
   localparam int PTSP_CTRL_PDOWN_BIT = 4;
   // status fields
   localparam int PTSP_STAT_BUSY_BIT = 0;
   localparam int PTSP_STAT_PDOWN_BIT = 1;
   localparam int PTSP_STAT_DBG_BIT = 2;
   localparam int PTSP_STAT_TEST_LSB = 3;
   localparam int PTSP_STAT_RST_BIT = 5;
   // cmd fields
   localparam int PTSP_CMD_CODE_LSB = 0;
   localparam int PTSP_CMD_HOLD_LSB = 8;

   // reset values and minimum hold
   localparam logic [3:0] PTSP_BKPT_RST = 4'h0;
   localparam logic [31:0] PTSP_DATA_RST = 32'h0000_0000;
   localparam logic [3:0] PTSP_HOLD_MIN = 4'h2;

   // processor status codes
   localparam logic [3:0] PTSP_ST_CONTINUE = 4'h0;
   localparam logic [3:0] PTSP_ST_INSN = 4'h1;
   localparam logic [3:0] PTSP_ST_RSVD_A = 4'h2;
   localparam logic [3:0] PTSP_ST_USER = 4'h3;
   localparam logic [3:0] PTSP_ST_PULSE = 4'h4;
   localparam logic [3:0] PTSP_ST_BRANCH = 4'h5;
   localparam logic [3:0] PTSP_ST_RSVD_B = 4'h6;
   localparam logic [3:0] PTSP_ST_RETURN = 4'h7;
   localparam logic [3:0] PTSP_ST_XFER1 = 4'h8;
   localparam logic [3:0] PTSP_ST_XFER4 = 4'hB;
   localparam logic [3:0] PTSP_ST_EXCEPT = 4'hC;
   localparam logic [3:0] PTSP_ST_EMUL = 4'hD;
   localparam logic [3:0] PTSP_ST_STOPPED = 4'hE;
   localparam logic [3:0] PTSP_ST_HALTED = 4'hF;

   // one event handed from the bus side to the trace side
   typedef struct packed {
      logic [3:0] code;
      logic [3:0] hold;
      logic [31:0] data;
   } ptsp_event_t;

   // trace-side states
   typedef enum logic [2:0] {
      PTSP_IDLE = 3'b001,
      PTSP_NIB = 3'b010,
      PTSP_HOLD = 3'b100
   } ptsp_state_t;

endpackage

/* ptsp_sync.sv */
// Purpose: two-flop synchroniser for levels entering a clock domain
// Assumes: each bit is an independent level or a toggle
// Notes: only the second stage is visible to the caller
`timescale 1ns/1ps
module ptsp_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] d_i,
   input wire logic [W-1:0] rst_val_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] hold_r;

   // both stages reset to zero; rst_val_i is applied outside as an xor
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_r <= '0;
         hold_r <= '0;
      end
      else
      begin
         meta_r <= d_i ^ rst_val_i;
         hold_r <= meta_r;
      end
   end

   assign q_o = hold_r ^ rst_val_i;

endmodule // ptsp_sync

/* ptsp_top.sv */
// Purpose: trace status and debug data port with test-mode pin logic
// Assumes: trace_clk_i is the core clock from the pll; sys_clk_i clocks apb
// Notes: software posts status events over apb; trace side replays them
// What this block does
// - lowest select high is debug, low scan
// - float input tristates outputs without any clock
// - scan mode is not affected by float
// - trace clock out at core clock rate
// - four-bit debug data shows data and breakpoints
// - status changes on trace clock, core state
// - execution event codes zero to seven
// - codes eight to eleven start byte transfers
// - codes twelve to fifteen show core stops
// - stop-type codes last several trace cycles
// - scan and debug share pins, select decides
// - reset starts exception, data bus released
// - low wake input ends power-down
`timescale 1ns/1ps
module ptsp_top (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic trace_clk_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic debug_interface_select_i,
   input wire logic [1:0] test_mode_hi_i,
   input wire logic output_float_n_i,
   input wire logic reset_in_n_i,
   input wire logic wake_up_n_i,
   output logic trace_clock_out_o,
   output logic [3:0] processor_status_code_o,
   output logic [3:0] debug_data_nibble_o,
   output logic trace_oe_o,
   output logic scan_owns_pins_o,
   output logic data_bus_oe_o,
   output logic power_down_o
);
   import ptsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, bus side
   logic [5:0] pin_s;
   logic dbg_mode_s;
   logic [1:0] test_hi_s;
   logic rst_in_act_s;
   logic wake_s;
   logic ack_tgl_s;
   logic ack_tgl_t;

   ptsp_sync #(.W(6)) u_sync_sys (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .d_i({ack_tgl_t, ~reset_in_n_i, ~wake_up_n_i, test_mode_hi_i, debug_interface_select_i}),
      .rst_val_i(6'h01),
      .q_o(pin_s)
   );
   assign dbg_mode_s = pin_s[0];
   assign test_hi_s = pin_s[2:1];
   assign wake_s = pin_s[3];
   assign rst_in_act_s = pin_s[4];
   assign ack_tgl_s = pin_s[5];

   ////////////////////////////////////////////////////////////////////////
   // apb slave
   logic setup_w;
   logic access_w;
   logic wr_ctrl_w;
   logic wr_data_w;
   logic wr_cmd_w;
   logic busy_w;
   logic code_bad_w;
   logic [3:0] bkpt_r;
   logic pdown_r;
   logic [31:0] data_r;
   ptsp_event_t evt_r;
   logic req_tgl_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;
   logic err_nxt;
   logic scan_r;
   logic bus_oe_r;

   assign setup_w = psel_i & ~penable_i;
   assign access_w = psel_i & penable_i & pready_r;
   assign busy_w = req_tgl_r ^ ack_tgl_s;
   assign code_bad_w = (pwdata_i[PTSP_CMD_CODE_LSB +: 4] == PTSP_ST_RSVD_A) |
                       (pwdata_i[PTSP_CMD_CODE_LSB +: 4] == PTSP_ST_RSVD_B);
   assign wr_ctrl_w = access_w & pwrite_i & ~pslverr_r & (paddr_i == PTSP_OFS_CTRL);
   assign wr_data_w = access_w & pwrite_i & ~pslverr_r & (paddr_i == PTSP_OFS_DATA);
   assign wr_cmd_w = access_w & pwrite_i & ~pslverr_r & (paddr_i == PTSP_OFS_CMD);

   // read data and error decided in the setup cycle
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      case (paddr_i)
         PTSP_OFS_CTRL:
         begin
            rd_nxt[PTSP_CTRL_BKPT_LSB +: 4] = bkpt_r;
            rd_nxt[PTSP_CTRL_PDOWN_BIT] = pdown_r;
         end
         PTSP_OFS_STAT:
         begin
            err_nxt = pwrite_i;
            rd_nxt[PTSP_STAT_BUSY_BIT] = busy_w;
            rd_nxt[PTSP_STAT_PDOWN_BIT] = pdown_r;
            rd_nxt[PTSP_STAT_DBG_BIT] = dbg_mode_s;
            rd_nxt[PTSP_STAT_TEST_LSB +: 2] = test_hi_s;
            rd_nxt[PTSP_STAT_RST_BIT] = rst_in_act_s;
         end
         PTSP_OFS_DATA:
         begin
            rd_nxt = data_r;
         end
         PTSP_OFS_CMD:
         begin
            err_nxt = pwrite_i & (busy_w | code_bad_w);
            rd_nxt[PTSP_CMD_CODE_LSB +: 4] = evt_r.code;
            rd_nxt[PTSP_CMD_HOLD_LSB +: 4] = evt_r.hold;
         end
         default:
         begin
            err_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= setup_w;
         pslverr_r <= setup_w & err_nxt;
         prdata_r <= setup_w ? rd_nxt : 32'h0000_0000;
      end
   end

   // control registers
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         bkpt_r <= PTSP_BKPT_RST;
         data_r <= PTSP_DATA_RST;
      end
      else
      begin
         if (wr_ctrl_w)
            bkpt_r <= pwdata_i[PTSP_CTRL_BKPT_LSB +: 4];
         if (wr_data_w)
            data_r <= pwdata_i;
      end
   end

   // power-down: software sets, low wake level clears, and a wake level beats a same-cycle set
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         pdown_r <= 1'b0;
      else if (wr_ctrl_w)
         pdown_r <= pwdata_i[PTSP_CTRL_PDOWN_BIT] & ~wake_s;
      else if (wake_s)
         pdown_r <= 1'b0;
   end

   // event launch: words stay frozen until the trace side acknowledges
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         evt_r <= '0;
         req_tgl_r <= 1'b0;
      end
      else if (wr_cmd_w)
      begin
         evt_r.code <= pwdata_i[PTSP_CMD_CODE_LSB +: 4];
         evt_r.hold <= (pwdata_i[PTSP_CMD_HOLD_LSB +: 4] < PTSP_HOLD_MIN) ? PTSP_HOLD_MIN :
                       pwdata_i[PTSP_CMD_HOLD_LSB +: 4];
         evt_r.data <= data_r;
         req_tgl_r <= ~req_tgl_r;
      end
   end

   // pin ownership and bus release
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         scan_r <= 1'b0;
         bus_oe_r <= 1'b0;
      end
      else
      begin
         scan_r <= ~dbg_mode_s;
         bus_oe_r <= ~rst_in_act_s;
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign power_down_o = pdown_r;
   assign scan_owns_pins_o = scan_r;
   assign data_bus_oe_o = bus_oe_r & output_float_n_i;

   ////////////////////////////////////////////////////////////////////////
   // trace side synchronisers
   logic [7:0] trc_s;
   logic req_tgl_t;
   logic dbg_t;
   logic rst_t;
   logic pdown_t;

   ptsp_sync #(.W(8)) u_sync_trc (
      .clk_i(trace_clk_i),
      .rst_b_i(rst_b_i),
      .d_i({bkpt_r, pdown_r, rst_in_act_s, dbg_mode_s, req_tgl_r}),
      .rst_val_i(8'h00),
      .q_o(trc_s)
   );
   assign req_tgl_t = trc_s[0];
   assign dbg_t = trc_s[1];
   assign rst_t = trc_s[2];
   assign pdown_t = trc_s[3];

   ////////////////////////////////////////////////////////////////////////
   // trace sequencer
   ptsp_state_t state_r;
   logic ack_r;
   logic [3:0] pst_r;
   logic [3:0] ddata_r;
   logic [31:0] shift_r;
   logic [3:0] cnt_r;
   logic oe_r;
   logic new_evt_w;
   logic [3:0] bkpt_t;

   assign ack_tgl_t = ack_r;
   assign new_evt_w = (req_tgl_t != ack_r) & (state_r == PTSP_IDLE);
   // breakpoint bits are quasi-static; each one passes two trace flops
   assign bkpt_t = trc_s[7:4];

   always_ff @(posedge trace_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_r <= PTSP_IDLE;
         ack_r <= 1'b0;
         pst_r <= PTSP_ST_CONTINUE;
         ddata_r <= 4'h0;
         shift_r <= 32'h0000_0000;
         cnt_r <= 4'h0;
      end
      else
      begin
         case (state_r)
            PTSP_IDLE:
            begin
               ddata_r <= bkpt_t;
               if (rst_t)
                  pst_r <= PTSP_ST_EXCEPT;
               else if (pdown_t)
                  pst_r <= PTSP_ST_STOPPED;
               else if (new_evt_w)
               begin
                  ack_r <= ~ack_r;
                  pst_r <= evt_r.code;
                  shift_r <= evt_r.data;
                  if (evt_r.code >= PTSP_ST_EXCEPT)
                  begin
                     cnt_r <= evt_r.hold - 4'h1;
                     state_r <= PTSP_HOLD;
                  end
                  else if (evt_r.code >= PTSP_ST_XFER1)
                  begin
                     cnt_r <= {1'b0, evt_r.code[1:0], 1'b1};
                     state_r <= PTSP_NIB;
                  end
               end
               else
                  pst_r <= PTSP_ST_CONTINUE;
            end
            PTSP_NIB:
            begin
               pst_r <= PTSP_ST_CONTINUE;
               ddata_r <= shift_r[3:0];
               shift_r <= {4'h0, shift_r[31:4]};
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h0)
                  state_r <= PTSP_IDLE;
            end
            PTSP_HOLD:
            begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1)
                  state_r <= PTSP_IDLE;
            end
            default:
            begin
               state_r <= PTSP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge trace_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         oe_r <= 1'b0;
      else
         oe_r <= dbg_t;
   end

   // forwarded clock at full rate from a posedge and a negedge toggle
   logic tck_p_r;
   logic tck_n_r;

   always_ff @(posedge trace_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         tck_p_r <= 1'b0;
      else
         tck_p_r <= ~tck_p_r;
   end

   always_ff @(negedge trace_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         tck_n_r <= 1'b0;
      else
         tck_n_r <= tck_p_r;
   end

   assign trace_clock_out_o = tck_p_r ^ tck_n_r;
   assign processor_status_code_o = pst_r;
   assign debug_data_nibble_o = ddata_r;
   assign trace_oe_o = oe_r & output_float_n_i;

endmodule // ptsp_top

/* ptsp_top_monitor.sv */
// Purpose: concurrent checks on the trace status port pins
// Assumes: one reset for both clock domains
// Notes: bound to ptsp_top below
`timescale 1ns/1ps
module ptsp_top_chk (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic trace_clk_i,
   input wire logic debug_interface_select_i,
   input wire logic output_float_n_i,
   input wire logic reset_in_n_i,
   input wire logic wake_up_n_i,
   input wire logic [3:0] processor_status_code_o,
   input wire logic trace_oe_o,
   input wire logic scan_owns_pins_o,
   input wire logic data_bus_oe_o,
   input wire logic power_down_o
);
   import ptsp_pkg::*;
   logic [3:0] pst;
   assign pst = processor_status_code_o;
   ////////////////////////////////////////////////////////////
   a_float_oe: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i) !output_float_n_i |-> !trace_oe_o && !data_bus_oe_o)
      else $error("driver enabled while float asserted");
   a_scan_owns: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i) !debug_interface_select_i [*4] |-> scan_owns_pins_o)
      else $error("scan does not own pins");
   a_debug_owns: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i) debug_interface_select_i [*4] |-> !scan_owns_pins_o)
      else $error("scan owns pins in debug mode");
   a_bus_release: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i) !reset_in_n_i [*4] |-> !data_bus_oe_o)
      else $error("data bus driven during reset");
   a_wake_exit: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i) !wake_up_n_i [*5] |-> !power_down_o)
      else $error("power-down kept with wake low");
   a_no_rsvd: assert property (
      @(posedge trace_clk_i) disable iff (!rst_b_i) pst != PTSP_ST_RSVD_A && pst != PTSP_ST_RSVD_B)
      else $error("reserved status code driven");
   a_short_code: assert property (
      @(posedge trace_clk_i) disable iff (!rst_b_i) pst inside {[1:7]} |=> pst == 4'h0)
      else $error("event code longer than one cycle");
   a_xfer_one: assert property (
      @(posedge trace_clk_i) disable iff (!rst_b_i) pst == PTSP_ST_XFER1 |=> (pst == 4'h0) [*2])
      else $error("one-byte transfer gap wrong");
   a_xfer_four: assert property (
      @(posedge trace_clk_i) disable iff (!rst_b_i) pst == PTSP_ST_XFER4 |=> (pst == 4'h0) [*8])
      else $error("four-byte transfer gap wrong");
   a_stop_hold: assert property (
      @(posedge trace_clk_i) disable iff (!rst_b_i) pst >= PTSP_ST_EXCEPT && pst != $past(pst) |=> $stable(pst))
      else $error("stop-type code held one cycle");
endmodule // ptsp_top_chk

bind ptsp_top ptsp_top_chk u_ptsp_top_chk (
   .sys_clk_i(sys_clk_i),
   .rst_b_i(rst_b_i),
   .trace_clk_i(trace_clk_i),
   .debug_interface_select_i(debug_interface_select_i),
   .output_float_n_i(output_float_n_i),
   .reset_in_n_i(reset_in_n_i),
   .wake_up_n_i(wake_up_n_i),
   .processor_status_code_o(processor_status_code_o),
   .trace_oe_o(trace_oe_o),
   .scan_owns_pins_o(scan_owns_pins_o),
   .data_bus_oe_o(data_bus_oe_o),
   .power_down_o(power_down_o)
);

/* ptsp_trace_cap.sv */
// Purpose: external trace capture model
// Assumes: samples status and nibbles on the trace clock
// Notes: keeps the last byte transfer it saw
`timescale 1ns/1ps
module ptsp_trace_cap (
   input wire logic trace_clk_i,
   input wire logic rst_b_i,
   input wire logic [3:0] status_i,
   input wire logic [3:0] nibble_i,
   output logic [31:0] word_o,
   output logic [3:0] code_o
);
   import ptsp_pkg::*;
   logic [3:0] left_r;
   logic [2:0] idx_r;
   always_ff @(posedge trace_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         left_r <= 4'h0;
         idx_r <= 3'h0;
         word_o <= 32'h0;
         code_o <= 4'h0;
      end
      else if (left_r != 4'h0)
      begin
         word_o[{idx_r, 2'b00} +: 4] <= nibble_i;
         idx_r <= idx_r + 3'h1;
         left_r <= left_r - 4'h1;
      end
      else if (status_i >= PTSP_ST_XFER1 && status_i <= PTSP_ST_XFER4)
      begin
         left_r <= {1'b0, status_i[1:0], 1'b0} + 4'h2;
         idx_r <= 3'h0;
         word_o <= 32'h0;
         code_o <= status_i;
      end
   end
endmodule // ptsp_trace_cap
